// File: hdl/qdc_core.sv
// Quad converter control: serial slave receiver, byte queue and register update.
`timescale 1ns/1ps
module qdc_core
   import qdc_pkg::*;
#(
   parameter int QUEUE_DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Serial bus
   input wire logic sclPin,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Address straps and load pin
   input wire logic slaveAddrPinHigh,
   input wire logic slaveAddrPinLow,
   input wire logic asyncLoadPin,
   // Register views
   output qdc_bank_t convOut,
   output qdc_bank_t stageOut
);
   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      qdc_rx_t rx;
      logic [3:0] bitCnt;
      logic [7:0] shift;
      logic isAddr;
      qdc_kind_t phase;
      logic pdSeen;
      logic sdaOe;
      logic push;
      qdc_entry_t pushData;
      logic sclPrev;
      logic sdaPrev;
      logic loadPrev;
      logic [7:0] ctrl;
      logic [7:0] msb;
      qdc_bank_t stage;
      qdc_bank_t conv;
   } qdc_core_st_t;

   qdc_core_st_t q;
   qdc_core_st_t d;
   qdc_pins_t pinRaw;
   qdc_pins_t pinS;
   logic [$bits(qdc_pins_t)-1:0] pinSync;
   logic sclRise;
   logic sclFall;
   logic startCond;
   logic stopCond;
   logic loadEdge;
   logic [6:0] ownAddr;
   logic addrHit;
   logic byteOk;
   logic fifoInReady;
   logic popValid;
   logic popReady;
   logic [$bits(qdc_entry_t)-1:0] popRaw;
   qdc_entry_t popData;
   logic commit;
   logic [1:0] mode;
   logic [1:0] sel;
   logic pdFlag;
   qdc_word_t word;

   // -----------------------------------------------------------------
   // Pin synchronisation and edge detection
   // -----------------------------------------------------------------
   assign pinRaw.scl = sclPin;
   assign pinRaw.sda = sdaIn;
   assign pinRaw.addrHigh = slaveAddrPinHigh;
   assign pinRaw.addrLow = slaveAddrPinLow;
   assign pinRaw.asyncLoad = asyncLoadPin;

   qdc_sync #(
      .WIDTH($bits(qdc_pins_t))
   ) u_sync (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .pinIn(pinRaw),
      .pinOut(pinSync)
   );

   assign pinS = qdc_pins_t'(pinSync);
   assign sclRise = pinS.scl & ~q.sclPrev;
   assign sclFall = ~pinS.scl & q.sclPrev;
   assign startCond = pinS.scl & q.sclPrev & q.sdaPrev & ~pinS.sda;
   assign stopCond = pinS.scl & q.sclPrev & ~q.sdaPrev & pinS.sda;
   assign loadEdge = pinS.asyncLoad & ~q.loadPrev;

   // The address byte is matched against the fixed prefix and the straps.
   assign ownAddr = {ADDR_HI, pinS.addrHigh, pinS.addrLow};
   assign addrHit = (q.shift[7:1] == ownAddr) && (q.shift[RW_BIT] == WRITE_DIR); // [RULE19]
   // After a power-down pair the phase is closed, so extra bytes are refused.
   assign byteOk = (q.phase != KIND_NONE) && fifoInReady; // [RULE21]

   // -----------------------------------------------------------------
   // Byte queue
   // -----------------------------------------------------------------
   // An asynchronous load takes the cycle, so the queue drain holds off.
   assign popReady = ~loadEdge;

   qdc_fifo #(
      .WIDTH($bits(qdc_entry_t)),
      .DEPTH(QUEUE_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .inValid(q.push),
      .inReady(fifoInReady),
      .inData(q.pushData),
      .outValid(popValid),
      .outReady(popReady),
      .outData(popRaw)
   );

   assign popData = qdc_entry_t'(popRaw);

   // -----------------------------------------------------------------
   // Word assembly
   // -----------------------------------------------------------------
   assign commit = popValid & popReady & (popData.kind == KIND_LSB);
   assign mode = q.ctrl[CTL_LOAD_HI:CTL_LOAD_LO];
   assign sel = q.ctrl[CTL_SEL_HI:CTL_SEL_LO];
   assign pdFlag = q.ctrl[CTL_PD];

   always_comb begin
      if (pdFlag) begin
         word = {q.msb[MSB_PD_HI:MSB_PD_LO], DATA_ZERO}; // [RULE10] [RULE16]
      end else begin
         word = {PD_NORMAL, q.msb, popData.data[LSB_NIB_HI:LSB_NIB_LO]}; // [RULE9] [RULE11]
      end
   end

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      d = q;
      d.push = 1'b0;
      d.sclPrev = pinS.scl;
      d.sdaPrev = pinS.sda;
      d.loadPrev = pinS.asyncLoad;
      case (q.rx)
         RX_BITS: begin
            if (sclRise) begin
               d.shift = {q.shift[6:0], pinS.sda};
               d.bitCnt = 4'(q.bitCnt + 1'b1);
            end else if (sclFall && q.bitCnt == BYTE_BITS) begin
               if (q.isAddr ? addrHit : byteOk) begin
                  d.sdaOe = 1'b1;
                  d.rx = RX_ACK;
               end else begin
                  d.rx = RX_SKIP;
               end
            end
         end
         RX_ACK: begin
            if (sclRise) begin
               d.bitCnt = ACK_BIT;
            end else if (sclFall && q.bitCnt == ACK_BIT) begin
               // The byte is handed on at the falling edge ending its acknowledge.
               d.sdaOe = 1'b0;
               d.rx = RX_BITS;
               d.bitCnt = BIT_ZERO;
               d.isAddr = 1'b0;
               if (q.isAddr) begin
                  d.phase = KIND_CTRL;
               end else begin
                  d.push = 1'b1; // [RULE12]
                  d.pushData = '{kind: q.phase, data: q.shift};
                  case (q.phase)
                     KIND_CTRL: begin
                        d.phase = KIND_MSB;
                        d.pdSeen = q.shift[CTL_PD];
                     end
                     KIND_MSB: begin
                        d.phase = KIND_LSB;
                     end
                     KIND_LSB: begin
                        d.phase = q.pdSeen ? KIND_NONE : KIND_MSB; // [RULE20] [RULE21]
                     end
                     default: begin
                        d.phase = KIND_NONE;
                     end
                  endcase
               end
            end
         end
         RX_IDLE, RX_SKIP: begin
            d.rx = q.rx;
         end
         default: begin
            d.rx = RX_IDLE;
         end
      endcase
      if (startCond) begin
         d.rx = RX_BITS;
         d.bitCnt = BIT_ZERO;
         d.isAddr = 1'b1;
         d.sdaOe = 1'b0;
         d.phase = KIND_NONE;
      end else if (stopCond) begin
         d.rx = RX_IDLE;
         d.sdaOe = 1'b0;
         d.phase = KIND_NONE;
      end

      if (popValid && popReady) begin
         case (popData.kind)
            KIND_CTRL: begin
               d.ctrl = popData.data; // [RULE18]
            end
            KIND_MSB: begin
               d.msb = popData.data;
            end
            KIND_LSB: begin
               case (mode)
                  LOAD_STAGE: begin
                     d.stage[sel] = word; // [RULE1] [RULE2]
                  end
                  LOAD_ONE: begin
                     d.stage[sel] = word;
                     d.conv[sel] = word; // [RULE3] [RULE4] [RULE17]
                  end
                  LOAD_ALL: begin
                     d.stage[sel] = word;
                     d.conv = d.stage; // [RULE5]
                  end
                  default: begin
                     if (!q.ctrl[CTL_SEL_HI]) begin
                        d.conv = q.stage; // [RULE6]
                     end else begin
                        for (int i = 0; i < CHANNELS; i++) begin
                           d.conv[i] = word; // [RULE7] [RULE8]
                        end
                     end
                  end
               endcase
            end
            default: begin
               d.ctrl = q.ctrl;
            end
         endcase
      end

      // The queue is stalled on this cycle, so staging cannot move under the copy.
      if (loadEdge) begin
         d.conv = q.stage; // [RULE14]
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0; // [RULE13] [RULE22]
      end else begin
         q <= d;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign sdaOut = 1'b0;
   assign sdaOe = q.sdaOe;
   assign convOut = q.conv;
   assign stageOut = q.stage;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_stageOnly;
      @(posedge clk_sys) disable iff (!rst_b)
      (commit && mode == LOAD_STAGE) |=> $stable(convOut);
   endproperty
   a_stageOnly: assert property (p_stageOnly) // [RULE1]
      else $error("Staging-only write changed a converter register.");

   property p_stageData;
      @(posedge clk_sys) disable iff (!rst_b)
      (commit && mode == LOAD_STAGE && !pdFlag)
         |=> stageOut[$past(sel)] == $past(word);
   endproperty
   a_stageData: assert property (p_stageData) // [RULE9]
      else $error("Staging register did not take the assembled value.");

   property p_stagePd;
      @(posedge clk_sys) disable iff (!rst_b)
      (commit && mode == LOAD_STAGE && pdFlag)
         |=> stageOut[$past(sel)][DATA_W-1:0] == DATA_ZERO;
   endproperty
   a_stagePd: assert property (p_stagePd) // [RULE2]
      else $error("Power-down write left data bits in staging.");

   property p_loadOne;
      @(posedge clk_sys) disable iff (!rst_b)
      (commit && mode == LOAD_ONE) |=> convOut[$past(sel)] == $past(word);
   endproperty
   a_loadOne: assert property (p_loadOne) // [RULE3]
      else $error("Selected converter register was not loaded.");

   property p_loadAll;
      @(posedge clk_sys) disable iff (!rst_b)
      (commit && mode == LOAD_ALL) |=> convOut == stageOut;
   endproperty
   a_loadAll: assert property (p_loadAll) // [RULE5]
      else $error("Converter bank does not match staging after load-all.");

   property p_bcastStored;
      @(posedge clk_sys) disable iff (!rst_b)
      (commit && mode == LOAD_BCAST && !q.ctrl[CTL_SEL_HI])
         |=> convOut == $past(stageOut);
   endproperty
   a_bcastStored: assert property (p_bcastStored) // [RULE6]
      else $error("Broadcast did not load stored staging values.");

   property p_bcastData;
      @(posedge clk_sys) disable iff (!rst_b)
      (commit && mode == LOAD_BCAST && q.ctrl[CTL_SEL_HI])
         |=> convOut == {CHANNELS{$past(word)}};
   endproperty
   a_bcastData: assert property (p_bcastData) // [RULE7]
      else $error("Broadcast did not load every channel with the word.");

   property p_asyncLoad;
      @(posedge clk_sys) disable iff (!rst_b)
      loadEdge |=> (convOut == stageOut) && $stable(stageOut);
   endproperty
   a_asyncLoad: assert property (p_asyncLoad) // [RULE14]
      else $error("Load pin edge did not copy staging to converters.");

   property p_addrNack;
      @(posedge clk_sys) disable iff (!rst_b)
      (q.rx == RX_BITS && sclFall && q.bitCnt == BYTE_BITS && q.isAddr
         && !addrHit && !startCond && !stopCond)
         |=> !sdaOe && q.rx == RX_SKIP;
   endproperty
   a_addrNack: assert property (p_addrNack) // [RULE19]
      else $error("Foreign address was acknowledged.");

   property p_pdOverrun;
      @(posedge clk_sys) disable iff (!rst_b)
      (q.rx == RX_BITS && sclFall && q.bitCnt == BYTE_BITS && !q.isAddr
         && q.phase == KIND_NONE && !startCond && !stopCond)
         |=> !sdaOe;
   endproperty
   a_pdOverrun: assert property (p_pdOverrun) // [RULE21]
      else $error("Byte after closed power-down pair was acknowledged.");

   property p_ackRelease;
      @(posedge clk_sys) disable iff (!rst_b)
      (q.rx == RX_ACK && sclFall && q.bitCnt == ACK_BIT && !q.isAddr
         && !startCond && !stopCond)
         |=> q.push && !sdaOe ##1 !q.push;
   endproperty
   a_ackRelease: assert property (p_ackRelease) // [RULE12]
      else $error("Data byte not handed on at the acknowledge falling edge.");
endmodule

// File: hdl/qdc_fifo.sv
// Parameterised first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
module qdc_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } qdc_fifo_st_t;

   qdc_fifo_st_t q;
   qdc_fifo_st_t d;
   logic doIn;
   logic doOut;

   assign inReady = (q.cnt != (AW+1)'(DEPTH));
   assign outValid = (q.cnt != '0);
   assign outData = q.mem[q.rd];
   assign doIn = inValid & inReady;
   assign doOut = outValid & outReady;

   always_comb begin
      d = q;
      if (doIn) begin
         d.mem[q.wr] = inData;
         d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : AW'(q.wr + 1'b1);
      end
      if (doOut) begin
         d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : AW'(q.rd + 1'b1);
      end
      d.cnt = (AW+1)'(q.cnt + (AW+1)'(doIn) - (AW+1)'(doOut));
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule

// File: hdl/qdc_pkg.sv
// Shared constants and types for the quad converter control block.
//
// Contract
// RULE1: Load 00, flag clear: write staging only.
// RULE2: Load 00, flag set: power-down code to staging.
// RULE3: Load 01, data: staging and converter of channel.
// RULE4: Load 01, flag set: power down one channel.
// RULE5: Load 10: write staging, load all converters.
// RULE6: Broadcast, bit2 clear: all converters from staging.
// RULE7: Broadcast, bit2 set: all converters get data.
// RULE8: Broadcast, bit2 and flag: power down all.
// RULE9: First data byte is value bits 11..4.
// RULE10: Flag set: first byte top bits are code.
// RULE11: Second byte upper nibble is bits 3..0.
// RULE12: Update at acknowledge falling edge after byte two.
// RULE13: Readback before any write returns zeros.
// RULE14: Load pin rising edge copies all staging.
// RULE15: Master pulses load pin after staging written.
// RULE16: Staging word: two code bits, twelve data.
// RULE17: Converter word same layout; write updates output.
// RULE18: Whole control byte latched in control register.
// RULE19: Address 10011, two pins, write bit zero.
// RULE20: Flag clear: repeated byte pairs until stop/start.
// RULE21: Flag set: exactly two data bytes accepted.
// RULE22: Reset clears staging and converter registers.
package qdc_pkg;
   localparam int CHANNELS = 4;
   localparam int DATA_W = 12;
   localparam int WORD_W = 14;
   localparam int FIFO_DEPTH = 32;
   localparam logic [4:0] ADDR_HI = 5'h13;
   localparam logic WRITE_DIR = 1'b0;
   localparam int RW_BIT = 0;
   localparam int CTL_LOAD_HI = 5;
   localparam int CTL_LOAD_LO = 4;
   localparam int CTL_SEL_HI = 2;
   localparam int CTL_SEL_LO = 1;
   localparam int CTL_PD = 0;
   localparam int MSB_PD_HI = 7;
   localparam int MSB_PD_LO = 6;
   localparam int LSB_NIB_HI = 7;
   localparam int LSB_NIB_LO = 4;
   localparam logic [1:0] LOAD_STAGE = 2'h0;
   localparam logic [1:0] LOAD_ONE = 2'h1;
   localparam logic [1:0] LOAD_ALL = 2'h2;
   localparam logic [1:0] LOAD_BCAST = 2'h3;
   localparam logic [1:0] PD_NORMAL = 2'h0;
   localparam logic [11:0] DATA_ZERO = 12'h000;
   localparam logic [3:0] BIT_ZERO = 4'h0;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] ACK_BIT = 4'h9;

   typedef logic [WORD_W-1:0] qdc_word_t;
   typedef qdc_word_t [CHANNELS-1:0] qdc_bank_t;
   typedef enum logic [1:0] {KIND_NONE, KIND_CTRL, KIND_MSB, KIND_LSB} qdc_kind_t;
   typedef enum logic [1:0] {RX_IDLE, RX_BITS, RX_ACK, RX_SKIP} qdc_rx_t;

   typedef struct packed {
      qdc_kind_t kind;
      logic [7:0] data;
   } qdc_entry_t;

   typedef struct packed {
      logic scl;
      logic sda;
      logic addrHigh;
      logic addrLow;
      logic asyncLoad;
   } qdc_pins_t;
endpackage

// File: hdl/qdc_sync.sv
// Two-stage synchroniser for pins from outside the clock domain.
`timescale 1ns/1ps
module qdc_sync #(
   parameter int WIDTH = 5
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Pins
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] pinOut
);
   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } qdc_sync_st_t;

   qdc_sync_st_t q;
   qdc_sync_st_t d;

   always_comb begin
      d.first = pinIn;
      d.second = q.first;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign pinOut = q.second;
endmodule

// File: verif/qdc_master.sv
// Serial bus master model that writes frames to the converter control block.
`timescale 1ns/1ps
module qdc_master (
   // Bus wires
   output logic scl,
   output wire logic sda,
   input wire logic sdaOe,
   input wire logic sdaOut
);
   logic sdaDrv;

   // Open-drain wire with a pull-up: while enabled, the device's output value joins the wire.
   assign sda = sdaDrv & (sdaOe ? sdaOut : 1'b1);

   // The bus clock stands high between frames.
   initial begin
      scl = 1'b1;
      sdaDrv = 1'b1;
   end

   // Start or repeated start: data falls while the clock is high.
   task automatic start();
      #200 sdaDrv = 1'b1;
      #200 scl = 1'b1;
      #200 sdaDrv = 1'b0;
      #400 scl = 1'b0;
   endtask

   // One 800 ns bus clock: data set in the low phase, sampled in the high one.
   task automatic clockBit(input logic b, output logic seen);
      #200 sdaDrv = b;
      #200 scl = 1'b1;
      #200 seen = sda;
      #200 scl = 1'b0;
   endtask

   // Eight bits, most significant first, then the acknowledge clock.
   task automatic sendByte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clockBit(v[i], s);
      end
      clockBit(1'b1, s);
      ack = ~s;
      // Longer low phase so the released wire cannot rise together with the clock.
      #400;
   endtask

   // Stop: data rises while the clock is high.
   task automatic stop();
      #200 sdaDrv = 1'b0;
      #200 scl = 1'b1;
      #400 sdaDrv = 1'b1;
      #400;
   endtask
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the quad converter control block.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top import qdc_pkg::*; ;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic addrHi = 1'b0;
   logic addrLo = 1'b0;
   logic loadPin = 1'b0;
   logic scl;
   wire sda;
   logic sdaOe;
   logic sdaOut;
   qdc_bank_t convOut;
   qdc_bank_t stageOut;
   qdc_bank_t expConv;
   qdc_bank_t expStage;
   int n_mismatch = 0;
   int n_compared = 0;

   always #50 clk_sys = ~clk_sys;

   qdc_master bfm (.scl(scl), .sda(sda), .sdaOe(sdaOe), .sdaOut(sdaOut));

   qdc_core #(.QUEUE_DEPTH(4)) DUT (.clk_sys(clk_sys), .rst_b(rst_b), .sclPin(scl),
      .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .slaveAddrPinHigh(addrHi),
      .slaveAddrPinLow(addrLo), .asyncLoadPin(loadPin), .convOut(convOut),
      .stageOut(stageOut));

   // ----------------------------------------
   // Expectation model
   // ----------------------------------------
   function automatic qdc_word_t wordOf(logic [7:0] c, logic [7:0] hi, logic [7:0] lo);
      if (c[CTL_PD]) return {hi[MSB_PD_HI:MSB_PD_LO], DATA_ZERO};
      return {PD_NORMAL, hi, lo[LSB_NIB_HI:LSB_NIB_LO]};
   endfunction

   task automatic apply(logic [7:0] c, logic [7:0] hi, logic [7:0] lo);
      qdc_word_t w;
      int ch;
      w = wordOf(c, hi, lo);
      ch = c[CTL_SEL_HI:CTL_SEL_LO];
      case (c[CTL_LOAD_HI:CTL_LOAD_LO])
         LOAD_STAGE: expStage[ch] = w;
         LOAD_ONE: begin
            expStage[ch] = w;
            expConv[ch] = w;
         end
         LOAD_ALL: begin
            expStage[ch] = w;
            expConv = expStage;
         end
         default: expConv = c[CTL_SEL_HI] ? {CHANNELS{w}} : expStage;
      endcase
   endtask

   task automatic checkAll();
      repeat (12) @(posedge clk_sys);
      for (int i = 0; i < CHANNELS; i++) begin
         `CHK(stageOut[i], expStage[i])
         `CHK(convOut[i], expConv[i])
      end
   endtask

   // Random phase offset keeps the bus clock unrelated to the system clock.
   task automatic frame(logic [7:0] adr, logic [7:0] c, logic [7:0] d[$], logic expAck,
         int nAck);
      logic ack;
      #($urandom_range(99));
      bfm.start();
      bfm.sendByte(adr, ack);
      `CHK(ack, expAck)
      bfm.sendByte(c, ack);
      `CHK(ack, expAck)
      foreach (d[i]) begin
         bfm.sendByte(d[i], ack);
         `CHK(ack, expAck && (i < nAck))
      end
      bfm.stop();
      @(posedge clk_sys);
   endtask

   task automatic finish_test();
      $display("Counts: %0d compared, %0d mismatched", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      logic [7:0] c;
      logic [7:0] hi;
      logic [7:0] lo;
      logic [7:0] q[$];
      void'($urandom(32'hB6F8));
      expConv = '0;
      expStage = '0;
      repeat (10) @(posedge clk_sys);
      #1 rst_b = 1'b1;
      repeat (4) @(posedge clk_sys);
      checkAll();
      // Every load, select and flag combination with random data and straps.
      for (int i = 0; i < 64; i++) begin
         #1 {addrHi, addrLo} = 2'($urandom);
         c = {2'($urandom), 6'(i)};
         hi = 8'($urandom);
         lo = 8'($urandom);
         if (c[CTL_PD]) begin
            hi = {hi[7:6], 6'h00};
            lo = 8'h00;
            q = '{hi, lo};
         end else begin
            q = '{hi, lo, lo, hi};
         end
         frame({ADDR_HI, addrHi, addrLo, WRITE_DIR}, c, q, 1'b1, q.size());
         apply(c, q[0], q[1]);
         if (q.size() > 2) apply(c, q[2], q[3]);
         checkAll();
      end
      // A byte beyond the power-down pair is refused.
      q = '{8'hC0, 8'h00, 8'h55};
      frame({ADDR_HI, addrHi, addrLo, WRITE_DIR}, 8'h11, q, 1'b1, 2);
      apply(8'h11, 8'hC0, 8'h00);
      checkAll();
      // A lone first data byte updates no staging or converter register.
      q = '{8'hAB};
      frame({ADDR_HI, addrHi, addrLo, WRITE_DIR}, 8'h12, q, 1'b1, 1);
      checkAll();
      // Foreign address and read direction are not acknowledged.
      q = '{8'hFF, 8'hF0};
      frame({ADDR_HI, ~addrHi, addrLo, WRITE_DIR}, 8'h10, q, 1'b0, 0);
      frame({ADDR_HI, addrHi, addrLo, 1'b1}, 8'h10, q, 1'b0, 0);
      checkAll();
      // Fill all staging registers, then one load pin pulse moves them together.
      for (int ch = 0; ch < CHANNELS; ch++) begin
         c = {5'h00, 2'(ch), 1'b0};
         q = '{8'($urandom), 8'($urandom)};
         frame({ADDR_HI, addrHi, addrLo, WRITE_DIR}, c, q, 1'b1, 2);
         apply(c, q[0], q[1]);
      end
      checkAll();
      #1 loadPin = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 loadPin = 1'b0;
      expConv = expStage;
      checkAll();
      // A reset in mid-run clears both banks, and the bus works again after it.
      #1 rst_b = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 rst_b = 1'b1;
      expConv = '0;
      expStage = '0;
      checkAll();
      c = 8'h16;
      q = '{8'($urandom), 8'($urandom)};
      frame({ADDR_HI, addrHi, addrLo, WRITE_DIR}, c, q, 1'b1, 2);
      apply(c, q[0], q[1]);
      checkAll();
      finish_test();
   end

   // About twice the expected run length.
   initial begin
      #6000000;
      n_mismatch++;
      finish_test();
   end
endmodule
